// file: design/dll_seq.sv
// Sequencer that moves DDR3L SDRAM from DLL-off to DLL-on with a clock change in self refresh.
`timescale 1ns/1ps
module dll_seq
  import dll_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic freq_ack,
  output logic freq_req,
  output logic cke,
  output logic odt,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [15:0] addr
);
  seq_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] dllk_cnt;
  logic dllk_run;
  logic dll_locked;
  logic done;
  logic zq_en;
  logic odt_en;
  logic [1:0] upd_idx;
  logic [15:0] mr [4];
  logic [CNT_W-1:0] tim [8];
  logic freq_ack_s1;
  logic freq_ack_s2;
  logic acc_pend;
  logic start;

  // Every access answers one cycle after it is raised. Waitrequest idles high so that it can
  // come straight from a flip-flop; it drops for the one cycle in which the access is taken.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end
  assign acc_pend = !avs_waitrequest;

  function automatic logic is_tim(input logic [3:0] a);
    return a >= REG_T_CKSRE && a <= REG_T_FREQ;
  endfunction : is_tim

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !acc_pend) begin
      case (avs_address)
        REG_STATUS: avs_readdata <= {28'h0, dll_locked, freq_req, done, state != S_IDLE};
        REG_CTRL: avs_readdata <= {29'h0, odt_en, zq_en, 1'b0};
        REG_MR0, REG_MR1, REG_MR2, REG_MR3: avs_readdata <= {16'h0, mr[avs_address[1:0] - 2'h2]};
        default: avs_readdata <= is_tim(avs_address) ? {16'h0, tim[avs_address[2:0] - 3'h6]}
                                                     : 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zq_en <= 1'b0;
      odt_en <= 1'b0;
      start <= 1'b0;
      mr[0] <= 16'h0;
      mr[1] <= 16'h0;
      mr[2] <= 16'h0;
      mr[3] <= 16'h0;
      tim[0] <= RST_CKSRE;
      tim[1] <= RST_CKSRX;
      tim[2] <= RST_XS;
      tim[3] <= RST_MRD;
      tim[4] <= RST_MOD;
      tim[5] <= RST_DLLK;
      tim[6] <= RST_ZQOPER;
      tim[7] <= RST_FREQ;
    end else begin
      start <= 1'b0;
      if (avs_write && acc_pend) begin
        case (avs_address)
          REG_CTRL: begin
            start <= avs_writedata[CTRL_START];
            zq_en <= avs_writedata[CTRL_ZQ_EN];
            odt_en <= avs_writedata[CTRL_ODT_EN];
          end
          REG_MR0, REG_MR1, REG_MR2, REG_MR3: mr[avs_address[1:0] - 2'h2] <= avs_writedata[15:0];
          default: begin
            if (is_tim(avs_address)) begin
              tim[avs_address[2:0] - 3'h6] <= avs_writedata[CNT_W-1:0];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      freq_ack_s1 <= 1'b0;
      freq_ack_s2 <= 1'b0;
    end else begin
      freq_ack_s1 <= freq_ack;
      freq_ack_s2 <= freq_ack_s1;
    end
  end

  // The lock timer runs from the DLL reset command independently of later waits.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dllk_cnt <= '0;
      dllk_run <= 1'b0;
      dll_locked <= 1'b0;
    end else if (state == S_MR0_RST) begin
      dllk_cnt <= tim[5];
      dllk_run <= 1'b1;
      dll_locked <= 1'b0;
    end else if (state == S_SRE) begin
      dll_locked <= 1'b0;
    end else if (dllk_run) begin
      dllk_cnt <= dllk_cnt - CNT_W'(1);
      if (dllk_cnt == CNT_W'(1)) begin
        dllk_run <= 1'b0;
        dll_locked <= 1'b1;
      end
    end
  end

  logic cnt_zero;
  assign cnt_zero = (cnt == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      cnt <= '0;
      done <= 1'b0;
      upd_idx <= 2'h0;
      freq_req <= 1'b0;
      cke <= 1'b1;
      odt <= 1'b0;
      {cs_n, ras_n, cas_n, we_n} <= CMD_DESEL;
      ba <= 3'h0;
      addr <= 16'h0;
    end else begin
      {cs_n, ras_n, cas_n, we_n} <= CMD_NOP;
      if (!cnt_zero) begin
        cnt <= cnt - CNT_W'(1);
      end
      case (state)
        S_IDLE: begin
          // Software starts only with banks precharged and termination off.
          if (start) begin
            done <= 1'b0;
            odt <= 1'b0;
            state <= S_SRE;
          end
        end
        S_SRE: begin
          {cs_n, ras_n, cas_n, we_n} <= CMD_SRE;
          cke <= 1'b0;
          cnt <= tim[0] - CNT_W'(1);
          state <= S_WAIT_CKSRE;
        end
        S_WAIT_CKSRE: if (cnt_zero) begin
          freq_req <= 1'b1;
          state <= S_FREQ;
        end
        S_FREQ: if (freq_ack_s2) begin
          freq_req <= 1'b0;
          cnt <= tim[1] - CNT_W'(1);
          state <= S_WAIT_CKSRX;
        end
        S_WAIT_CKSRX: if (cnt_zero) begin
          state <= S_SRX;
        end
        S_SRX: begin
          // Exit is a NOP with CKE rising; CKE stays high until the next switch.
          cke <= 1'b1;
          odt <= 1'b0;
          cnt <= tim[2] - CNT_W'(1);
          state <= S_WAIT_XS;
        end
        S_WAIT_XS: if (cnt_zero) begin
          state <= S_MR1_ON;
        end
        S_MR1_ON: begin
          {cs_n, ras_n, cas_n, we_n} <= CMD_MRS;
          ba <= BA_MR1;
          addr <= mr[1] & ~(16'h1 << DLL_OFF_BIT);
          cnt <= tim[3] - CNT_W'(1);
          state <= S_MR0_RST;
        end
        S_MR0_RST: if (cnt_zero) begin
          {cs_n, ras_n, cas_n, we_n} <= CMD_MRS;
          ba <= BA_MR0;
          addr <= mr[0] | (16'h1 << DLL_RST_BIT);
          cnt <= tim[3] - CNT_W'(1);
          upd_idx <= 2'h0;
          state <= S_MR_UPD;
        end
        S_MR_UPD: if (cnt_zero) begin
          {cs_n, ras_n, cas_n, we_n} <= CMD_MRS;
          ba <= {1'b0, upd_idx};
          addr <= (upd_idx == 2'h1) ? (mr[1] & ~(16'h1 << DLL_OFF_BIT)) : mr[upd_idx];
          upd_idx <= upd_idx + 2'h1;
          if (upd_idx == 2'h3) begin
            cnt <= tim[4] - CNT_W'(1);
            state <= S_WAIT_MOD;
          end else begin
            cnt <= tim[3] - CNT_W'(1);
          end
        end
        S_WAIT_MOD: if (cnt_zero) begin
          state <= zq_en ? S_ZQCL : S_WAIT_FIN;
        end
        S_ZQCL: begin
          {cs_n, ras_n, cas_n, we_n} <= CMD_ZQCL;
          addr <= 16'h1 << ZQ_LONG_BIT;
          cnt <= tim[6] - CNT_W'(1);
          state <= S_WAIT_FIN;
        end
        S_WAIT_FIN: if (cnt_zero && dll_locked) begin
          odt <= odt_en;
          done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  sre_to_ckesrx_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_SRE) |=> !cke [*2]) else $error("CKE not low after entry");
  cke_held_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_WAIT_XS || state == S_MR_UPD || state == S_WAIT_MOD) |-> cke)
    else $error("CKE dropped");
  odt_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_MR_UPD || state == S_WAIT_XS || state == S_ZQCL) |-> !odt)
    else $error("ODT high during relock");
  mr1_dll_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_MR1_ON) |=> (ba == BA_MR1 && !addr[DLL_OFF_BIT] && !cs_n && !ras_n))
    else $error("MR1 DLL enable wrong");
  mr0_rst_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_MR0_RST && cnt_zero) |=> (ba == BA_MR0 && addr[DLL_RST_BIT] && !we_n))
    else $error("MR0 reset wrong");
  freq_only_sr_a: assert property (@(posedge clk) disable iff (!rst_n)
    freq_req |-> !cke) else $error("Clock change outside self refresh");
  lock_before_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(done) |-> dll_locked) else $error("Done before DLL lock");
  xs_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state == S_WAIT_XS) |-> (cnt == tim[2] - CNT_W'(1)))
    else $error("tXS count wrong");
  mrd_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_MR1_ON) |=> (state == S_MR0_RST) [*3])
    else $error("tMRD gap short");
  zq_after_mod_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_ZQCL) |-> $past(state) == S_WAIT_MOD) else $error("ZQCL too early");
  srx_cke_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_SRX) |=> (cke && {cs_n, ras_n, cas_n, we_n} == CMD_NOP))
    else $error("Self refresh exit wrong");
  wait_nop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state inside {S_WAIT_CKSRE, S_WAIT_CKSRX, S_WAIT_XS, S_WAIT_MOD, S_WAIT_FIN})
    |=> ({cs_n, ras_n, cas_n, we_n} == CMD_NOP)) else $error("Command during wait");
  zq_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_ZQCL) |=> ({cs_n, ras_n, cas_n, we_n} == CMD_ZQCL && addr[ZQ_LONG_BIT]))
    else $error("Long calibration wrong");

  start_c: cover property (@(posedge clk) disable iff (!rst_n) start && state == S_IDLE);
  freq_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(freq_req));
  zq_c: cover property (@(posedge clk) disable iff (!rst_n) state == S_ZQCL);
  done_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(done));
endmodule : dll_seq

// file: inc/dll_seq_pkg.sv
// Package with command codes, register map and timing constants for the DLL switch sequencer.
package dll_seq_pkg;
  // Command encodings on {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'hf;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_SRE = 4'h1;
  localparam logic [3:0] CMD_ZQCL = 4'h6;
  // Mode register bank addresses.
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam int DLL_OFF_BIT = 0;
  localparam int DLL_RST_BIT = 8;
  localparam int ZQ_LONG_BIT = 10;
  // Register word addresses on avs_address (one index per register).
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MR0 = 4'h2;
  localparam logic [3:0] REG_MR1 = 4'h3;
  localparam logic [3:0] REG_MR2 = 4'h4;
  localparam logic [3:0] REG_MR3 = 4'h5;
  localparam logic [3:0] REG_T_CKSRE = 4'h6;
  localparam logic [3:0] REG_T_CKSRX = 4'h7;
  localparam logic [3:0] REG_T_XS = 4'h8;
  localparam logic [3:0] REG_T_MRD = 4'h9;
  localparam logic [3:0] REG_T_MOD = 4'ha;
  localparam logic [3:0] REG_T_DLLK = 4'hb;
  localparam logic [3:0] REG_T_ZQOPER = 4'hc;
  localparam logic [3:0] REG_T_FREQ = 4'hd;
  // Control bits.
  localparam int CTRL_START = 0;
  localparam int CTRL_ZQ_EN = 1;
  localparam int CTRL_ODT_EN = 2;
  // Status bits.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FREQ_REQ = 2;
  localparam int ST_DLL_LOCKED = 3;
  localparam int CNT_W = 16;
  // Timing defaults in the clock period of the controller.
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_CKSRE_NS = 10;
  localparam int T_CKSRX_NS = 10;
  localparam int T_XS_NS = 170;
  localparam int T_MRD_NCK = 4;
  localparam int T_MOD_NCK = 12;
  localparam int T_DLLK_NCK = 512;
  localparam int T_ZQOPER_NCK = 256;
  // Rounding up a time in ns to whole cycles, never below one.
  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction : ns_to_cyc
  localparam logic [CNT_W-1:0] RST_CKSRE = ns_to_cyc(T_CKSRE_NS);
  localparam logic [CNT_W-1:0] RST_CKSRX = ns_to_cyc(T_CKSRX_NS);
  localparam logic [CNT_W-1:0] RST_XS = ns_to_cyc(T_XS_NS);
  localparam logic [CNT_W-1:0] RST_MRD = CNT_W'(T_MRD_NCK);
  localparam logic [CNT_W-1:0] RST_MOD = CNT_W'(T_MOD_NCK);
  localparam logic [CNT_W-1:0] RST_DLLK = CNT_W'(T_DLLK_NCK);
  localparam logic [CNT_W-1:0] RST_ZQOPER = CNT_W'(T_ZQOPER_NCK);
  localparam logic [CNT_W-1:0] RST_FREQ = 16'h0010;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_SRE = 4'h1,
    S_WAIT_CKSRE = 4'h2,
    S_FREQ = 4'h3,
    S_WAIT_CKSRX = 4'h4,
    S_SRX = 4'h5,
    S_WAIT_XS = 4'h6,
    S_MR1_ON = 4'h7,
    S_MR0_RST = 4'h8,
    S_MR_UPD = 4'h9,
    S_WAIT_MOD = 4'ha,
    S_ZQCL = 4'hb,
    S_WAIT_FIN = 4'hc
  } seq_state_t;
endpackage : dll_seq_pkg

// file: test/ddr_dev_model.sv
// Behavioural DDR3L memory that tracks MR1 and counts command timing faults.
`timescale 1ns/1ps
module ddr_dev_model
  import dll_seq_pkg::*;
#(
  parameter int T_CKSRE = 2,
  parameter int T_CKSRX = 3,
  parameter int T_XS = 5,
  parameter int T_MRD = 4,
  parameter int T_MOD = 6,
  parameter int T_DLLK = 40,
  parameter int T_ZQ = 20
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic odt,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr,
  input wire logic freq_req,
  output logic [15:0] mr1,
  output logic [7:0] mrs_count,
  output logic [7:0] zq_count,
  output logic [7:0] faults,
  output logic ready
);
  logic [3:0] cmd;
  logic in_sr, win, rst_seen, zq_seen, dll_on;
  int since_sr, since_srx, since_mrs, since_rst, since_zq, since_frq;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign dll_on = !mr1[DLL_OFF_BIT];
  assign ready = dll_on && rst_seen && since_rst >= T_DLLK && since_mrs >= T_MOD
    && (!zq_seen || since_zq >= T_ZQ);
  // Counters hold the edge distance to their last event, so a gap of N edges reads N; since_frq reads N-1.
  always @(posedge clk) begin
    if (!rst_n) begin
      {in_sr, win, rst_seen, zq_seen} <= 4'h0;
      {faults, mrs_count, zq_count} <= 24'h0;
      mr1 <= 16'h1;
      since_sr <= 1000;
      since_srx <= 1000;
      since_mrs <= 1000;
      since_rst <= 1000;
      since_zq <= 1000;
      since_frq <= 1000;
    end else begin
      // Edges since the clock change was last requested; exit must not follow too soon.
      since_frq <= since_frq + 1;
      if (freq_req) since_frq <= 0;
      since_sr <= since_sr + 1;
      since_srx <= since_srx + 1;
      since_mrs <= since_mrs + 1;
      since_rst <= since_rst + 1;
      since_zq <= since_zq + 1;
      if (cmd == CMD_SRE && !cke) begin
        {in_sr, rst_seen, zq_seen} <= 3'h4;
        {mrs_count, zq_count} <= 16'h0;
        since_sr <= 1;
      end
      if (freq_req && (!in_sr || since_sr < T_CKSRE)) faults <= faults + 8'h1;
      if (in_sr && cke) begin
        if (since_frq < T_CKSRX) faults <= faults + 8'h1;
        in_sr <= 1'h0;
        win <= 1'h1;
        since_srx <= 1;
      end
      if (win && (!cke || odt)) faults <= faults + 8'h1;
      if (win && rst_seen && since_rst >= T_DLLK) win <= 1'h0;
      if (cmd == CMD_MRS) begin
        mrs_count <= mrs_count + 8'h1;
        since_mrs <= 1;
        if (in_sr || since_srx < T_XS || since_mrs < T_MRD) faults <= faults + 8'h1;
        if (ba == BA_MR1) mr1 <= addr;
        if (ba == BA_MR0 && addr[DLL_RST_BIT] && !rst_seen) begin
          rst_seen <= 1'h1;
          since_rst <= 1;
          if (!dll_on) faults <= faults + 8'h1;
        end
      end
      if (cmd == CMD_ZQCL) begin
        zq_count <= zq_count + 8'h1;
        zq_seen <= 1'h1;
        since_zq <= 1;
        if (since_mrs < T_MOD) faults <= faults + 8'h1;
      end
    end
  end
endmodule : ddr_dev_model

// file: test/dll_seq_bench.sv
// Self-checking bench for the DLL switch sequencer against a behavioural memory.
`timescale 1ns/1ps
module dll_seq_bench;
  import dll_seq_pkg::*;
  typedef struct {logic wr; logic [3:0] a; logic [31:0] d;} row_t;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, freq_ack, freq_req;
  logic cke, odt, cs_n, ras_n, cas_n, we_n, ready;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0] ba;
  logic [15:0] addr, mr1;
  logic [7:0] mrs_count, zq_count, faults;
  int miscompares = 0;
  int samples_checked = 0;
  row_t rows [23] = '{'{1'h0, REG_T_CKSRE, 32'h1}, '{1'h0, REG_T_CKSRX, 32'h1},
    '{1'h0, REG_T_XS, 32'h4}, '{1'h0, REG_T_MRD, 32'h4}, '{1'h0, REG_T_MOD, 32'hc},
    '{1'h0, REG_T_DLLK, 32'h200}, '{1'h0, REG_T_ZQOPER, 32'h100}, '{1'h0, REG_STATUS, 32'h0},
    '{1'h1, REG_STATUS, 32'hf}, '{1'h0, REG_STATUS, 32'h0}, '{1'h1, 4'hf, 32'h5},
    '{1'h0, 4'hf, 32'h0}, '{1'h1, REG_T_CKSRE, 32'h2}, '{1'h1, REG_T_CKSRX, 32'h3},
    '{1'h1, REG_T_XS, 32'h5}, '{1'h1, REG_T_DLLK, 32'h28}, '{1'h1, REG_T_ZQOPER, 32'h14},
    '{1'h1, REG_T_MOD, 32'h6}, '{1'h1, REG_MR0, 32'h420}, '{1'h1, REG_MR1, 32'h45},
    '{1'h1, REG_MR2, 32'h18}, '{1'h1, REG_MR3, 32'h4}, '{1'h0, REG_MR1, 32'h45}};
  dll_seq u_dll_seq (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .freq_ack(freq_ack),
    .freq_req(freq_req), .cke(cke), .odt(odt), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));
  ddr_dev_model u_ddr_dev_model (.clk(clk), .rst_n(rst_n), .cke(cke), .odt(odt),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .freq_req(freq_req), .mr1(mr1), .mrs_count(mrs_count), .zq_count(zq_count),
    .faults(faults), .ready(ready));
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic stop(input string nm);
    miscompares++;
    $display("ERROR %s wait ran out", nm);
    complete_run();
  endtask : stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // The request is held until the edge that samples waitrequest low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = avs_readdata;
    if (avs_waitrequest !== 1'h0) stop("waitrequest");
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask : bus
  task automatic wfr(input logic v);
    int n;
    n = 0;
    while (freq_req !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (freq_req !== v) stop("freq_req");
  endtask : wfr
  task automatic regs();
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk("register", rows[i].d, q);
    end
    $display("register rows done");
  endtask : regs
  task automatic run(input logic zq, input logic oe);
    int n;
    bus(1'h1, REG_CTRL, {29'h0, oe, zq, 1'h1});
    wfr(1'h1);
    // A second start while busy must not restart the sequence.
    bus(1'h1, REG_CTRL, {29'h0, oe, zq, 1'h1});
    repeat (3) @(posedge clk);
    freq_ack <= 1'h1;
    wfr(1'h0);
    freq_ack <= 1'h0;
    n = 0;
    q = 32'h0;
    while (q[ST_DONE] !== 1'h1 && n < 200) begin
      bus(1'h0, REG_STATUS, 32'h0);
      n++;
    end
    if (q[ST_DONE] !== 1'h1) stop("done");
    chk("status", 32'ha, q);
    chk("faults", 32'h0, faults);
    chk("mr1", 32'h44, mr1);
    chk("mrs count", 32'h6, mrs_count);
    chk("zq count", zq, zq_count);
    chk("ready", 32'h1, ready);
    chk("odt", oe, odt);
    $display("switch zq %0d odt %0d done", zq, oe);
  endtask : run
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst_n, avs_read, avs_write, freq_ack} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    regs();
    run(1'h1, 1'h1);
    run(1'h0, 1'h0);
    bus(1'h1, REG_CTRL, 32'h1);
    wfr(1'h1);
    rst_n <= 1'h0;
    repeat (6) @(posedge clk);
    chk("reset pins", 32'h5e, {cke, odt, cs_n, ras_n, cas_n, we_n, freq_req});
    rst_n <= 1'h1;
    @(posedge clk);
    $display("reset in mid sequence done");
    regs();
    run(1'h1, 1'h0);
    complete_run();
  end
endmodule : dll_seq_bench
